// ===== rtl/cgt_regs.svh
// Constants of the carrier generator timer
`ifndef CGT_REGS_SVH
`define CGT_REGS_SVH
`define CGT_CNT_W        8
`define CGT_CNT_ZERO     8'h00
`define CGT_CKS_W        3
`define CGT_CKS_DIV1     3'h0
`define CGT_CKS_MAX      3'h7
`define CGT_DIV_W        7
`define CGT_XFER_DLY     2'h2
`define CGT_HW_SETTLE    3
`endif

// ===== rtl/cgt_pkg.sv
// Types shared by the carrier generator timer
`default_nettype none
package cgt_pkg;
   typedef logic [7:0] cgt_cnt_t;
   typedef struct packed {
      logic       timer_run_enable;
      logic       partner_timer_enable;
      logic       remote_output_enable;
      logic       output_gate_buffer;
      logic [2:0] count_clock_select;
   } cgt_ctrl_s;
   typedef struct packed {
      logic     compare_match_irq;
      logic     output_gate_active;
      logic     carrier_level;
      cgt_cnt_t count;
   } cgt_stat_s;
   typedef enum logic {CGT_CMP_LOW, CGT_CMP_HIGH} cgt_sel_e;
endpackage
`default_nettype wire

// ===== rtl/cgt_tick_div.sv
// Count clock enable divider: one tick every 2**select system clocks
`default_nettype none
`include "cgt_regs.svh"
module cgt_tick_div (
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic [2:0] count_clock_select,
   output logic            tick
);
   logic [`CGT_DIV_W-1:0] div_reg;
   logic [`CGT_DIV_W-1:0] div_next;
   logic [`CGT_DIV_W-1:0] mask;
   assign mask     = (`CGT_DIV_W'(1) << count_clock_select) - `CGT_DIV_W'(1);
   assign div_next = ((div_reg & mask) == mask) ? '0 : div_reg + `CGT_DIV_W'(1);
   assign tick     = (div_reg & mask) == mask;
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_next;
      end
   end
endmodule
`default_nettype wire

// ===== rtl/cgt_core.sv
// Carrier generator timer: 8-bit alternating compare counter with gated output
// How it works
// RULE1: software keeps compare values between 01H and FFH
// RULE2: new high width needs three count clocks
// RULE3: remote enable set before counting starts
// RULE4: counter stopped while both enables low; code stops it whenever timer_run_enable is low
// RULE5: run starts counting, carrier held inactive
// RULE6: low match: irq, invert, clear, select high
// RULE7: high match: irq, invert, clear, select low
// RULE8: equal compares give half duty carrier
// RULE9: partner irq synchronised into count clock pulse
// RULE10: synced pulse copies gate buffer to active
// RULE11: gate low, carrier low: pin low
// RULE12: gate high passes carrier at rising edge
// RULE13: gate drop keeps current high phase whole
// RULE14: high width write latched until old match
// RULE15: next high match uses new value
// RULE16: pin follows remote enable and gate table
// RULE17: transfer on second count clock after pulse
// RULE18: software never rewrites low width while running
// RULE19: software spaces gate buffer writes two clocks
// RULE20: run clear stops, clears, idles, silences irq
`default_nettype none
`include "cgt_regs.svh"
module cgt_core
   import cgt_pkg::*;
(
   input  wire logic      clk_sys,
   input  wire logic      sys_rst,
   input  wire cgt_ctrl_s ctrl,
   input  wire cgt_cnt_t  low_width_compare,
   input  wire cgt_cnt_t  high_width_compare,
   input  wire logic      high_width_write,
   input  wire logic      partner_timer_irq,
   output var cgt_stat_s  status,
   output logic           carrier_output_pin
);
   import cgt_pkg::*;

   // ------------------------------------------------------------
   // Count clock and partner pulse synchroniser
   // ------------------------------------------------------------
   logic tick;
   cgt_tick_div u_div (
      .clk_sys            (clk_sys),
      .sys_rst            (sys_rst),
      .count_clock_select (ctrl.count_clock_select),
      .tick               (tick)
   );

   logic       irq_meta_reg;
   logic       irq_sync_reg;
   logic       irq_prev_reg;
   logic       irq_seen_reg;
   logic       synced_partner_pulse;
   logic [1:0] xfer_cnt_reg;
   logic       gate_active_reg;

   // Partner pulse may be shorter than a count clock, so catch its edge first
   assign synced_partner_pulse = irq_seen_reg & tick;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         irq_meta_reg <= 1'b0;
         irq_sync_reg <= 1'b0;
         irq_prev_reg <= 1'b0;
         irq_seen_reg <= 1'b0;
      end else begin
         irq_meta_reg <= partner_timer_irq;                      // [RULE9]
         irq_sync_reg <= irq_meta_reg;
         irq_prev_reg <= irq_sync_reg;
         irq_seen_reg <= (irq_sync_reg & ~irq_prev_reg) | (irq_seen_reg & ~tick); // [RULE9]
      end
   end

   // ------------------------------------------------------------
   // Gate master/slave transfer
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         xfer_cnt_reg    <= 2'h0;
         gate_active_reg <= 1'b0;
      end else if (tick) begin
         if (synced_partner_pulse) begin
            xfer_cnt_reg <= `CGT_XFER_DLY - 2'h1;                // [RULE17]
         end else if (xfer_cnt_reg != 2'h0) begin
            xfer_cnt_reg <= xfer_cnt_reg - 2'h1;
         end
         if (xfer_cnt_reg == 2'h1) begin
            gate_active_reg <= ctrl.output_gate_buffer;          // [RULE10] [RULE17]
         end
      end
   end

   // ------------------------------------------------------------
   // Counter, compare select and carrier
   // ------------------------------------------------------------
   cgt_cnt_t count_reg;
   cgt_cnt_t high_active_reg;
   cgt_cnt_t high_latch_reg;
   logic     high_pend_reg;
   cgt_sel_e sel_reg;
   logic     carrier_reg;
   logic     started_reg;
   logic     irq_reg;
   logic     running;
   cgt_cnt_t cmp_value;
   logic     match;

   assign running   = ctrl.timer_run_enable;                      // [RULE4]
   assign cmp_value = (sel_reg == CGT_CMP_LOW) ? low_width_compare : high_active_reg;
   assign match     = running & started_reg & tick & (count_reg == cmp_value);

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         high_latch_reg <= `CGT_CNT_ZERO;
         high_pend_reg  <= 1'b0;
      end else if (high_width_write) begin
         high_latch_reg <= high_width_compare;                   // [RULE14]
         high_pend_reg  <= 1'b1;
      end else if (match && sel_reg == CGT_CMP_HIGH) begin
         high_pend_reg  <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         count_reg       <= `CGT_CNT_ZERO;
         high_active_reg <= `CGT_CNT_ZERO;
         sel_reg         <= CGT_CMP_LOW;
         carrier_reg     <= 1'b0;
         started_reg     <= 1'b0;
         irq_reg         <= 1'b0;
      end else if (!running) begin
         count_reg   <= `CGT_CNT_ZERO;                            // [RULE20]
         sel_reg     <= CGT_CMP_LOW;
         carrier_reg <= 1'b0;
         started_reg <= 1'b0;
         irq_reg     <= 1'b0;
         // A write just before run must still be the first high width
         if (high_width_write) begin
            high_active_reg <= high_width_compare;               // [RULE14]
         end else if (high_pend_reg) begin
            high_active_reg <= high_latch_reg;
         end
      end else begin
         irq_reg <= match;                                       // [RULE6] [RULE7]
         if (tick && !started_reg) begin
            started_reg <= 1'b1;                                 // [RULE5]
         end else if (match) begin
            count_reg   <= `CGT_CNT_ZERO;                         // [RULE6] [RULE7]
            carrier_reg <= ~carrier_reg;                         // [RULE8]
            sel_reg     <= (sel_reg == CGT_CMP_LOW) ? CGT_CMP_HIGH : CGT_CMP_LOW;
            if (sel_reg == CGT_CMP_HIGH && high_pend_reg) begin
               high_active_reg <= high_latch_reg;                // [RULE14] [RULE15]
            end
         end else if (tick) begin
            count_reg <= count_reg + 8'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // Output gating
   // ------------------------------------------------------------
   logic pass_reg;
   logic pin_reg;
   logic carrier_rise;
   logic pass_next;
   logic pin_next;

   assign carrier_rise = match & ~carrier_reg;
   // Gate opens only on a carrier rise and closes only once the high phase ends
   assign pass_next = carrier_rise ? gate_active_reg :            // [RULE12]
                      (~carrier_reg ? 1'b0 : pass_reg);           // [RULE13]
   assign pin_next  = ~ctrl.remote_output_enable ? gate_active_reg : // [RULE16]
                      (carrier_rise ? gate_active_reg :
                       (match ? 1'b0 : (carrier_reg & pass_reg))); // [RULE11]

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pass_reg <= 1'b0;
         pin_reg  <= 1'b0;
      end else begin
         pass_reg <= pass_next;
         pin_reg  <= pin_next;
      end
   end

   assign carrier_output_pin        = pin_reg;
   assign status = '{compare_match_irq:  irq_reg,
                     output_gate_active: gate_active_reg,
                     carrier_level:      carrier_reg,
                     count:              count_reg};

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_stop;
      @(posedge clk_sys) disable iff (sys_rst)
      !running |=> (count_reg == 8'h00) && !carrier_reg && !irq_reg;
   endproperty
   a_stop: assert property (p_stop) else $error("counter not stopped"); // [RULE4] [RULE20]

   property p_start_idle;
      @(posedge clk_sys) disable iff (sys_rst)
      $rose(running) |=> !carrier_reg;
   endproperty
   a_start_idle: assert property (p_start_idle) else $error("carrier active at start"); // [RULE5]

   property p_low_match;
      @(posedge clk_sys) disable iff (sys_rst)
      (match && sel_reg == CGT_CMP_LOW) |=> irq_reg && carrier_reg && count_reg == 8'h00
         && sel_reg == CGT_CMP_HIGH;
   endproperty
   a_low_match: assert property (p_low_match) else $error("low match effect wrong"); // [RULE6]

   property p_high_match;
      @(posedge clk_sys) disable iff (sys_rst)
      (match && sel_reg == CGT_CMP_HIGH && running) |=> irq_reg && !carrier_reg
         && sel_reg == CGT_CMP_LOW;
   endproperty
   a_high_match: assert property (p_high_match) else $error("high match effect wrong"); // [RULE7]

   property p_toggle_only_on_match;
      @(posedge clk_sys) disable iff (sys_rst)
      running && !match |=> $stable(carrier_reg);
   endproperty
   a_toggle_only_on_match: assert property (p_toggle_only_on_match) else $error("stray toggle"); // [RULE8]

   property p_transfer;
      @(posedge clk_sys) disable iff (sys_rst)
      (tick && xfer_cnt_reg == 2'h1) |=> gate_active_reg == $past(ctrl.output_gate_buffer);
   endproperty
   a_transfer: assert property (p_transfer) else $error("gate transfer lost"); // [RULE10] [RULE17]

   property p_pin_low;
      @(posedge clk_sys) disable iff (sys_rst)
      (!gate_active_reg && !carrier_reg && !pass_reg) |=> !pin_reg;
   endproperty
   a_pin_low: assert property (p_pin_low) else $error("pin not low"); // [RULE11]

   property p_hold_high;
      @(posedge clk_sys) disable iff (sys_rst)
      (ctrl.remote_output_enable && pin_reg && carrier_reg && !match) |=> pin_reg;
   endproperty
   a_hold_high: assert property (p_hold_high) else $error("high phase cut"); // [RULE13]

   property p_new_high;
      @(posedge clk_sys) disable iff (sys_rst)
      (match && sel_reg == CGT_CMP_HIGH && high_pend_reg && running)
         |=> high_active_reg == $past(high_latch_reg);
   endproperty
   a_new_high: assert property (p_new_high) else $error("latched value not applied"); // [RULE14] [RULE15]

   property p_irq_pulse;
      @(posedge clk_sys) disable iff (sys_rst)
      irq_reg |=> !irq_reg;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq wider than one clock"); // [RULE6] [RULE7]

   property p_count_step;
      @(posedge clk_sys) disable iff (sys_rst)
      (running && started_reg && tick && !match) |=> count_reg == $past(count_reg) + 8'h01;
   endproperty
   a_count_step: assert property (p_count_step) else $error("count did not step"); // [RULE5]

   property p_count_hold;
      @(posedge clk_sys) disable iff (sys_rst)
      (running && !tick) |=> $stable(count_reg);
   endproperty
   a_count_hold: assert property (p_count_hold) else $error("count moved off tick"); // [RULE5]

   property p_sync_pulse;
      @(posedge clk_sys) disable iff (sys_rst)
      synced_partner_pulse |=> xfer_cnt_reg == 2'h1;
   endproperty
   a_sync_pulse: assert property (p_sync_pulse) else $error("pulse not armed"); // [RULE9] [RULE17]

   property p_latch_hold;
      @(posedge clk_sys) disable iff (sys_rst)
      (running && !(match && sel_reg == CGT_CMP_HIGH)) |=> $stable(high_active_reg);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("high width changed early"); // [RULE14]

   property p_gate_hold;
      @(posedge clk_sys) disable iff (sys_rst)
      !(tick && xfer_cnt_reg == 2'h1) |=> $stable(gate_active_reg);
   endproperty
   a_gate_hold: assert property (p_gate_hold) else $error("gate moved off transfer"); // [RULE10]

   property p_remote_off;
      @(posedge clk_sys) disable iff (sys_rst)
      !ctrl.remote_output_enable |=> pin_reg == $past(gate_active_reg);
   endproperty
   a_remote_off: assert property (p_remote_off) else $error("pin not equal to gate"); // [RULE16]

   property p_closed_rise;
      @(posedge clk_sys) disable iff (sys_rst)
      (carrier_rise && !gate_active_reg && ctrl.remote_output_enable) |=> !pin_reg;
   endproperty
   a_closed_rise: assert property (p_closed_rise) else $error("closed gate passed rise"); // [RULE11] [RULE12]
endmodule
`default_nettype wire

// ===== verif/cgt_partner_timer.sv
// Partner interval timer model that pulses the gating interrupt
`default_nettype none
module cgt_partner_timer #(
   parameter int PERIOD = 40
) (
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   input  wire logic enable,
   output logic      partner_timer_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_reg;
   // Period kept well above six count clocks so every pulse is seen
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !enable) begin
         cnt_reg           <= 8'h00;
         partner_timer_irq <= 1'b0;
      end else begin
         cnt_reg           <= (cnt_reg == 8'(PERIOD - 1)) ? 8'h00 : cnt_reg + 8'h01;
         partner_timer_irq <= (cnt_reg == 8'(PERIOD - 1));
      end
   end
endmodule
`default_nettype wire

// ===== verif/carrier_generator_timer_tb_top.sv
// Self-checking bench of the carrier generator timer
`default_nettype none
module carrier_generator_timer_tb_top;
   import cgt_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic      clk_sys = 0, sys_rst = 1, hw_wr = 0, pirq, pin, prv;
   cgt_ctrl_s ctrl = '0;
   cgt_cnt_t  low = 8'h01, high = 8'h01;
   cgt_stat_s st;
   int        n_fail = 0, n_tests = 0, cyc = 0, seed = 5, g, n, m;
   always #25 clk_sys = ~clk_sys;
   cgt_core cgt_core_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .ctrl(ctrl),
      .low_width_compare(low), .high_width_compare(high), .high_width_write(hw_wr),
      .partner_timer_irq(pirq), .status(st), .carrier_output_pin(pin));
   cgt_partner_timer cgt_partner_timer_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .enable(ctrl.partner_timer_enable), .partner_timer_irq(pirq));
   // ------------------------------------------------------------
   // Checking helpers
   // ------------------------------------------------------------
   task automatic wrap_up();
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 60000) begin
         n_fail++;
         wrap_up();
      end
   end
   function automatic int gap(input int v, input int s);
      return (v + 1) << s;
   endfunction
   task automatic wait_irq(output int k);
      k = 0;
      do begin
         @(negedge clk_sys);
         k++;
      end while (st.compare_match_irq !== 1'b1 && k < 2100);
   endtask
   task automatic write_high(input int v);
      high  = v[7:0];
      hw_wr = 1;
      @(negedge clk_sys);
      hw_wr = 0;
   endtask
   // Gate transfer is paced by partner pulses, so buffer writes stay spaced
   task automatic gate_to(input logic v);
      ctrl.output_gate_buffer = v;
      g = 0;
      while (pirq !== 1'b1 && g < 200) begin @(negedge clk_sys); g++; end
      g = 0;
      while (st.output_gate_active !== v && g < 20) begin @(negedge clk_sys); g++; end
      chk(g >= 3 && g <= 8, 1);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic run_pair(input int nn, input int mm, input int s);
      ctrl.count_clock_select = s[2:0];
      low = nn[7:0];
      write_high(mm);
      ctrl.timer_run_enable = 1;
      g = 0;
      while (st.compare_match_irq !== 1'b1 && g < 2100) begin
         chk(st.carrier_level, 0);
         @(negedge clk_sys);
         g++;
      end
      chk(st.count, 8'h00);
      chk(st.carrier_level, 1);
      wait_irq(g);
      chk(g, gap(mm, s));
      chk(st.carrier_level, 0);
      wait_irq(g);
      chk(g, gap(nn, s));
   endtask
   task automatic stop_run();
      ctrl.timer_run_enable = 0;
      repeat (2) @(negedge clk_sys);
      chk(st.carrier_level, 0);
      repeat (40) begin
         chk(st.count, 8'h00);
         chk(st.compare_match_irq, 0);
         @(negedge clk_sys);
      end
   endtask
   initial begin
      repeat (2) @(negedge clk_sys);
      sys_rst = 0;
      chk({st.compare_match_irq, st.output_gate_active, st.carrier_level, pin}, 4'h0);
      chk(st.count, 8'h00);
      ctrl.remote_output_enable = 1;
      run_pair(1, 1, 0);
      stop_run();
      run_pair(255, 254, 0);
      stop_run();
      for (int i = 0; i < 4; i++) begin
         n = 1 + ($unsigned($random(seed)) % 20);
         m = 1 + ($unsigned($random(seed)) % 20);
         run_pair(n, m, i % 2);
         stop_run();
      end
      run_pair(6, 4, 0);
      write_high(9);
      wait_irq(g);
      chk(g, 4);
      wait_irq(g);
      chk(g, 7);
      wait_irq(g);
      chk(g, 10);
      ctrl.partner_timer_enable = 1;
      gate_to(1);
      while (st.carrier_level !== 1'b0) @(negedge clk_sys);
      while (st.carrier_level !== 1'b1) @(negedge clk_sys);
      repeat (40) begin
         @(negedge clk_sys);
         chk(pin, st.carrier_level);
      end
      gate_to(0);
      prv = st.carrier_level;
      while (prv === 1'b1) begin
         chk(pin, 1);
         @(negedge clk_sys);
         prv = st.carrier_level;
      end
      @(negedge clk_sys);
      repeat (30) begin
         chk(pin, 0);
         @(negedge clk_sys);
      end
      ctrl.remote_output_enable = 0;
      for (int v = 1; v >= 0; v--) begin
         gate_to(v[0]);
         repeat (2) @(negedge clk_sys);
         repeat (20) begin
            chk(pin, v[0]);
            @(negedge clk_sys);
         end
      end
      ctrl.partner_timer_enable = 0;
      stop_run();
      wrap_up();
   end
endmodule
`default_nettype wire
